// *** hw/diagnostic_status_registers.sv ***
// Overview of operation
// - stages 27,28 individual code: 00 ground, 01 open, 10 battery, 11 healthy
// - stages 25,26 individual code: 00 supply, 01 open, 10 ground, 11 healthy
// - upper stage register shows four 2-bit fields or one 8-bit bridge code
// - bridge codes 01,05,04,02,03,07 faults or running, ff healthy
// - key-on bit 1 above upper threshold, 0 below lower threshold
// - relay overcurrent bit 1 while driver off after overcurrent, else 0
// - bit5 flywheel diag on; bit4 fault only in fully adaptive mode
// - tracking supply 2 in bits 3:2, supply 1 in 1:0, 2-bit codes
// - tracking overload code wins over overvoltage or over-temperature
// - reset-cause top bit set after timeout reset
// - first aggregate fault bit set on faults of main stages and ignition
// - outputs-disabled flag cleared by software reset command and reset pin
// - bit7 tracking over-temperature; bit6 stage or ignition over-temperature
// - bit5 relay over-temperature; bit4 low regulator over-temperature
// - bit3 set after long 5 V undervoltage reset, else 0
// - long undervoltage event latched even when its reset is masked
// - reset-cause and overtemperature bits clear on read, except the outputs-disabled bit1 of the reset-cause register; set bit means fault since last read
// - bit1 frame length error; bit0 stream timeout
`timescale 1ns/10ps
module diagnostic_status_registers #(
  parameter int NUM_STAGES = 4
) (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              reset_pin,
  input  wire logic                              software_reset_command,
  input  wire logic                              rd_en,
  input  wire logic [3:0]                        rd_addr,
  output      logic [7:0]                        rd_data,
  output      logic                              rd_valid,
  output      logic                              rd_hit,
  input  wire logic                              bridge_mode,
  input  wire diag_status_pkg::stage_fault_t [NUM_STAGES-1:0] stage_fault,
  input  wire diag_status_pkg::bridge_fault_t    second_bridge_fault,
  input  wire diag_status_pkg::stage_fault_t [3:0] ignition_fault,
  input  wire logic                              key_on_high,
  input  wire logic                              key_on_low,
  input  wire logic                              main_relay_overcurrent_off,
  input  wire logic                              flywheel_diag_active,
  input  wire logic                              flywheel_fully_adaptive,
  input  wire logic                              flywheel_sensor_fault,
  input  wire diag_status_pkg::track_fault_t [1:0] tracking_fault,
  input  wire diag_status_pkg::monitor_events_t  events,
  output      logic                              outputs_disabled
);

  // elaboration guard: the layout only serves four stages
  if (NUM_STAGES != 4) begin : g_bad_stages
    $error("NUM_STAGES must be 4");
  end

  // ==========================================================
  // field encoders
  function automatic logic [1:0] std_code(input diag_status_pkg::stage_fault_t f);
    if (f.gnd) std_code = diag_status_pkg::CODE_GND_FAULT;
    else if (f.open) std_code = diag_status_pkg::CODE_OPEN_LOAD;
    else if (f.bat) std_code = diag_status_pkg::CODE_BAT_FAULT;
    else std_code = diag_status_pkg::CODE_HEALTHY;
  endfunction : std_code

  function automatic logic [1:0] swap_code(input diag_status_pkg::stage_fault_t f);
    if (f.bat) swap_code = diag_status_pkg::CODE_GND_FAULT;
    else if (f.open) swap_code = diag_status_pkg::CODE_OPEN_LOAD;
    else if (f.gnd) swap_code = diag_status_pkg::CODE_BAT_FAULT;
    else swap_code = diag_status_pkg::CODE_HEALTHY;
  endfunction : swap_code

  function automatic logic [1:0] trk_code(input diag_status_pkg::track_fault_t f);
    if (f.overload) trk_code = diag_status_pkg::CODE_TRK_OVLD;
    else if (f.overvolt || f.overtemp) trk_code = diag_status_pkg::CODE_TRK_OVOT;
    else trk_code = diag_status_pkg::CODE_TRK_OK;
  endfunction : trk_code

  // ==========================================================
  // upper configurable stage register
  logic [7:0] stage_fields;
  logic [7:0] bridge_code;
  logic [7:0] config_upper;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_STAGES; gi++) begin : g_stage
      if (gi >= 2) begin : g_std
        assign stage_fields[2*gi +: 2] = std_code(stage_fault[gi]);
      end else begin : g_swap
        assign stage_fields[2*gi +: 2] = swap_code(stage_fault[gi]);
      end
    end
  endgenerate

  always_comb begin
    case (second_bridge_fault)
      diag_status_pkg::BR_GND_OFF: bridge_code = diag_status_pkg::BRIDGE_GND_OFF;
      diag_status_pkg::BR_BAT_OFF: bridge_code = diag_status_pkg::BRIDGE_BAT_OFF;
      diag_status_pkg::BR_OL_OFF:  bridge_code = diag_status_pkg::BRIDGE_OL_OFF;
      diag_status_pkg::BR_OL_ON:   bridge_code = diag_status_pkg::BRIDGE_OL_ON;
      diag_status_pkg::BR_OVC_ON:  bridge_code = diag_status_pkg::BRIDGE_OVC_ON;
      diag_status_pkg::BR_RUNNING: bridge_code = diag_status_pkg::BRIDGE_RUNNING;
      default:                     bridge_code = diag_status_pkg::BRIDGE_OK;
    endcase
  end

  assign config_upper = bridge_mode ? bridge_code : stage_fields;

  // ==========================================================
  // live status registers
  logic [7:0] ignition_diag;
  logic [7:0] sensor_relay;
  logic       key_on_ff;
  logic       nxt_key_on;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_ign
      assign ignition_diag[2*gi +: 2] = std_code(ignition_fault[gi]);
    end
  endgenerate

  // hysteresis: hold between thresholds
  assign nxt_key_on = key_on_high ? 1'b1 : (key_on_low ? 1'b0 : key_on_ff);

  always_ff @(posedge clk) begin
    if (sys_rst) key_on_ff <= 1'b0;
    else key_on_ff <= nxt_key_on;
  end

  assign sensor_relay = {key_on_ff,
                         main_relay_overcurrent_off,
                         flywheel_diag_active,
                         flywheel_sensor_fault & flywheel_fully_adaptive,
                         trk_code(tracking_fault[1]),
                         trk_code(tracking_fault[0])};

  // ==========================================================
  // sticky registers, set wins over read clear
  logic [7:0] reset_fault_ff;
  logic [7:0] overtemp_ff;
  logic [7:0] nxt_reset_fault;
  logic [7:0] nxt_overtemp;
  logic [7:0] reset_fault_set;
  logic [7:0] overtemp_set;
  logic       read_reset_fault;
  logic       read_overtemp;
  logic       dis_clear;
  logic [7:0] rc_after_read;

  assign read_reset_fault = rd_en && (rd_addr == diag_status_pkg::ADDR_RESET_FAULT);
  assign read_overtemp    = rd_en && (rd_addr == diag_status_pkg::ADDR_OVERTEMP);
  assign dis_clear        = software_reset_command || reset_pin;
  assign rc_after_read    = read_reset_fault ? (diag_status_pkg::KEEP_ON_READ & reset_fault_ff)
                                             : reset_fault_ff;

  assign reset_fault_set = {events.timeout_reset,
                            events.main_stages_fault,
                            events.short_undervolt_reset,
                            events.config_stages_fault,
                            events.five_volt_overvoltage,
                            events.three_volt_undervoltage,
                            events.outputs_disable_set,
                            events.battery_overvoltage};

  assign overtemp_set = {events.tracking_overtemp,
                         events.stage_overtemp,
                         events.relay_overtemp,
                         events.low_regulator_overtemp,
                         events.long_undervolt_reset,
                         1'b0,
                         events.frame_length_error,
                         events.stream_timeout_error};

  always_comb begin
    nxt_reset_fault = reset_fault_set | rc_after_read;
    if (dis_clear) nxt_reset_fault[diag_status_pkg::OUTPUTS_DISABLED_BIT] = 1'b0;
    else if (events.outputs_disable_set) nxt_reset_fault[diag_status_pkg::OUTPUTS_DISABLED_BIT] = 1'b1;
    nxt_overtemp = overtemp_set | (read_overtemp ? 8'h00 : overtemp_ff);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_fault_ff <= diag_status_pkg::STICKY_RESET;
      overtemp_ff    <= diag_status_pkg::STICKY_RESET;
    end else begin
      reset_fault_ff <= nxt_reset_fault;
      overtemp_ff    <= nxt_overtemp;
    end
  end

  assign outputs_disabled = reset_fault_ff[diag_status_pkg::OUTPUTS_DISABLED_BIT];

  // ==========================================================
  // read port
  logic [7:0] rd_mux;
  logic       hit;
  logic [7:0] rd_data_ff;
  logic       rd_valid_ff;

  always_comb begin
    hit = 1'b1;
    case (rd_addr)
      diag_status_pkg::ADDR_SENSOR_RELAY: rd_mux = sensor_relay;
      diag_status_pkg::ADDR_RESET_FAULT:  rd_mux = reset_fault_ff;
      diag_status_pkg::ADDR_OVERTEMP:     rd_mux = overtemp_ff;
      diag_status_pkg::ADDR_IGNITION:     rd_mux = ignition_diag;
      diag_status_pkg::ADDR_CONFIG_UPPER: rd_mux = config_upper;
      default: begin
        rd_mux = 8'h00;
        hit    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_en;
      if (rd_en) rd_data_ff <= rd_mux;
    end
  end

  assign rd_data  = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_hit   = rd_en & hit;

  // ==========================================================
  // checks
  property p_ot_clear_on_read;
    @(posedge clk) disable iff (sys_rst)
      (read_overtemp && overtemp_set == 8'h00) |=> (overtemp_ff == 8'h00);
  endproperty
  a_ot_clear_on_read: assert property (p_ot_clear_on_read)
    else $error("overtemp register not cleared by read");

  property p_set_wins;
    @(posedge clk) disable iff (sys_rst)
      (events.timeout_reset && read_reset_fault) |=> reset_fault_ff[7];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("timeout reset flag lost on read");

  property p_dis_clear;
    @(posedge clk) disable iff (sys_rst)
      dis_clear |=> !outputs_disabled;
  endproperty
  a_dis_clear: assert property (p_dis_clear)
    else $error("outputs disabled not cleared");

  property p_uv_latch;
    @(posedge clk) disable iff (sys_rst)
      events.long_undervolt_reset ##1 !read_overtemp |=> overtemp_ff[3];
  endproperty
  a_uv_latch: assert property (p_uv_latch)
    else $error("long undervoltage flag not held");

  property p_flywheel_limited;
    @(posedge clk) disable iff (sys_rst)
      !flywheel_fully_adaptive |-> !sensor_relay[4];
  endproperty
  a_flywheel_limited: assert property (p_flywheel_limited)
    else $error("flywheel fault shown in limited mode");

  property p_trk_priority;
    @(posedge clk) disable iff (sys_rst)
      tracking_fault[0].overload |-> sensor_relay[1:0] == diag_status_pkg::CODE_TRK_OVLD;
  endproperty
  a_trk_priority: assert property (p_trk_priority)
    else $error("overload not preferred");

  property p_key_hold;
    @(posedge clk) disable iff (sys_rst)
      (!key_on_high && !key_on_low) |=> (key_on_ff == $past(key_on_ff));
  endproperty
  a_key_hold: assert property (p_key_hold)
    else $error("key-on status moved between thresholds");

  property p_bridge_ok;
    @(posedge clk) disable iff (sys_rst)
      (bridge_mode && second_bridge_fault == diag_status_pkg::BR_OK)
        |-> config_upper == diag_status_pkg::BRIDGE_OK;
  endproperty
  a_bridge_ok: assert property (p_bridge_ok)
    else $error("bridge healthy code wrong");

  property p_read_data;
    @(posedge clk) disable iff (sys_rst)
      (rd_en && rd_addr == diag_status_pkg::ADDR_OVERTEMP)
        |=> rd_valid && rd_data == $past(overtemp_ff);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not the register before clear");

  property p_rc_set;
    @(posedge clk) disable iff (sys_rst)
      (reset_fault_set != 8'h00 && !dis_clear)
        |=> (reset_fault_ff & $past(reset_fault_set)) == $past(reset_fault_set);
  endproperty
  a_rc_set: assert property (p_rc_set)
    else $error("reset cause event not latched");

  property p_rc_hold;
    @(posedge clk) disable iff (sys_rst)
      (!read_reset_fault && !dis_clear)
        |=> (reset_fault_ff & $past(reset_fault_ff)) == $past(reset_fault_ff);
  endproperty
  a_rc_hold: assert property (p_rc_hold)
    else $error("reset cause flag lost without a read");

  property p_ot_set;
    @(posedge clk) disable iff (sys_rst)
      (overtemp_set != 8'h00)
        |=> (overtemp_ff & $past(overtemp_set)) == $past(overtemp_set);
  endproperty
  a_ot_set: assert property (p_ot_set)
    else $error("overtemp event not latched");

  property p_ot_hold;
    @(posedge clk) disable iff (sys_rst)
      !read_overtemp
        |=> (overtemp_ff & $past(overtemp_ff)) == $past(overtemp_ff);
  endproperty
  a_ot_hold: assert property (p_ot_hold)
    else $error("overtemp flag lost without a read");

  property p_dis_set;
    @(posedge clk) disable iff (sys_rst)
      (events.outputs_disable_set && !dis_clear)
        |=> outputs_disabled;
  endproperty
  a_dis_set: assert property (p_dis_set)
    else $error("outputs disabled not set");

  property p_key_high;
    @(posedge clk) disable iff (sys_rst)
      key_on_high
        |=> key_on_ff;
  endproperty
  a_key_high: assert property (p_key_high)
    else $error("key-on status not set above upper threshold");

  property p_stage28_gnd;
    @(posedge clk) disable iff (sys_rst)
      (!bridge_mode && stage_fault[3].gnd)
        |-> config_upper[7:6] == diag_status_pkg::CODE_GND_FAULT;
  endproperty
  a_stage28_gnd: assert property (p_stage28_gnd)
    else $error("upper stage ground code wrong");

  property p_stage25_bat;
    @(posedge clk) disable iff (sys_rst)
      (!bridge_mode && stage_fault[0].bat)
        |-> config_upper[1:0] == diag_status_pkg::CODE_GND_FAULT;
  endproperty
  a_stage25_bat: assert property (p_stage25_bat)
    else $error("lower stage supply code wrong");

endmodule : diagnostic_status_registers

// *** hw/diag_status_pkg.sv ***
package diag_status_pkg;

  // ==========================================================
  // register addresses (4-bit frame address)
  localparam logic [3:0] ADDR_SENSOR_RELAY = 4'h3;
  localparam logic [3:0] ADDR_RESET_FAULT  = 4'h7;
  localparam logic [3:0] ADDR_OVERTEMP     = 4'hb;
  localparam logic [3:0] ADDR_IGNITION     = 4'he;
  localparam logic [3:0] ADDR_CONFIG_UPPER = 4'ha;

  // ==========================================================
  // field codes
  localparam logic [1:0] CODE_GND_FAULT  = 2'h0;
  localparam logic [1:0] CODE_OPEN_LOAD  = 2'h1;
  localparam logic [1:0] CODE_BAT_FAULT  = 2'h2;
  localparam logic [1:0] CODE_HEALTHY    = 2'h3;
  localparam logic [1:0] CODE_TRK_OVLD   = 2'h1;
  localparam logic [1:0] CODE_TRK_OVOT   = 2'h2;
  localparam logic [1:0] CODE_TRK_OK     = 2'h3;

  localparam logic [7:0] BRIDGE_GND_OFF  = 8'h01;
  localparam logic [7:0] BRIDGE_BAT_OFF  = 8'h05;
  localparam logic [7:0] BRIDGE_OL_OFF   = 8'h04;
  localparam logic [7:0] BRIDGE_OL_ON    = 8'h02;
  localparam logic [7:0] BRIDGE_OVC_ON   = 8'h03;
  localparam logic [7:0] BRIDGE_RUNNING  = 8'h07;
  localparam logic [7:0] BRIDGE_OK       = 8'hff;

  localparam logic [7:0] STICKY_RESET    = 8'h00;
  localparam logic [7:0] KEEP_ON_READ    = 8'h02;
  localparam int         OUTPUTS_DISABLED_BIT     = 1;

  // ==========================================================
  // carriers
  typedef enum logic [2:0] {
    BR_OK, BR_GND_OFF, BR_BAT_OFF, BR_OL_OFF, BR_OL_ON, BR_OVC_ON, BR_RUNNING
  } bridge_fault_t;

  typedef struct packed {
    logic       gnd;
    logic       bat;
    logic       open;
  } stage_fault_t;

  typedef struct packed {
    logic       overload;
    logic       overvolt;
    logic       overtemp;
  } track_fault_t;

  typedef struct packed {
    logic       timeout_reset;
    logic       short_undervolt_reset;
    logic       five_volt_overvoltage;
    logic       three_volt_undervoltage;
    logic       battery_overvoltage;
    logic       long_undervolt_reset;
    logic       tracking_overtemp;
    logic       stage_overtemp;
    logic       relay_overtemp;
    logic       low_regulator_overtemp;
    logic       frame_length_error;
    logic       stream_timeout_error;
    logic       main_stages_fault;
    logic       config_stages_fault;
    logic       outputs_disable_set;
  } monitor_events_t;

endpackage : diag_status_pkg

// *** verif/diag_host_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// host side: frame reads, request held across the sampling edge
module diag_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  input  wire logic       rd_hit,
  output      logic       rd_en,
  output      logic [3:0] rd_addr
);
  initial begin
    rd_en   = 1'b0;
    rd_addr = 4'h5;
  end

  task automatic read(input logic [3:0] a, output logic [7:0] d, output logic v,
                      output logic h);
    @(negedge clk);
    rd_en   = 1'b1;
    rd_addr = a;
    #1 h    = rd_hit;
    @(negedge clk);
    rd_en   = 1'b0;
    rd_addr = ~a;
    v       = rd_valid;
    d       = rd_data;
  endtask : read

  // two reads on consecutive edges
  task automatic read2(input logic [3:0] a, output logic [7:0] d0, output logic [7:0] d1);
    @(negedge clk);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge clk);
    d0      = rd_data;
    @(negedge clk);
    rd_en   = 1'b0;
    rd_addr = ~a;
    d1      = rd_data;
  endtask : read2
endmodule : diag_host_model

// *** verif/diagnostic_status_registers_tb_top.sv ***
`timescale 1ns/10ps
module diagnostic_status_registers_tb_top;
  logic                                clk = 1'b0;
  logic                                sys_rst = 1'b1;
  logic                                reset_pin = 1'b0;
  logic                                software_reset_command = 1'b0;
  logic                                bridge_mode = 1'b0;
  diag_status_pkg::stage_fault_t [3:0] stage_fault = '0;
  diag_status_pkg::bridge_fault_t      second_bridge_fault = diag_status_pkg::BR_OK;
  diag_status_pkg::stage_fault_t [3:0] ignition_fault = '0;
  logic                                key_on_high = 1'b0;
  logic                                key_on_low = 1'b1;
  logic                                main_relay_overcurrent_off = 1'b0;
  logic                                flywheel_diag_active = 1'b0;
  logic                                flywheel_fully_adaptive = 1'b0;
  logic                                flywheel_sensor_fault = 1'b0;
  diag_status_pkg::track_fault_t [1:0] tracking_fault = '0;
  diag_status_pkg::monitor_events_t    events = '0;
  logic                                rd_en, rd_valid, rd_hit, outputs_disabled, v, h;
  logic [3:0]                          rd_addr;
  logic [7:0]                          rd_data, d, d1;
  int                                  mismatches = 0;
  int                                  samples_checked = 0;
  int                                  cycles = 0;

  diagnostic_status_registers u_diagnostic_status_registers (
    .clk(clk), .sys_rst(sys_rst), .reset_pin(reset_pin),
    .software_reset_command(software_reset_command), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit), .bridge_mode(bridge_mode),
    .stage_fault(stage_fault), .second_bridge_fault(second_bridge_fault),
    .ignition_fault(ignition_fault), .key_on_high(key_on_high), .key_on_low(key_on_low),
    .main_relay_overcurrent_off(main_relay_overcurrent_off),
    .flywheel_diag_active(flywheel_diag_active),
    .flywheel_fully_adaptive(flywheel_fully_adaptive),
    .flywheel_sensor_fault(flywheel_sensor_fault), .tracking_fault(tracking_fault),
    .events(events), .outputs_disabled(outputs_disabled));

  diag_host_model u_diag_host_model (
    .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit),
    .rd_en(rd_en), .rd_addr(rd_addr));

  // ==========================================================
  // shared checks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    u_diag_host_model.read(a, d, v, h);
    check("rd_valid", {7'h0, v}, 8'h01);
    check(what, d, exp);
  endtask : rdchk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdchk(4'h7, 8'h00, "reset_fault");
    rdchk(4'hb, 8'h00, "overtemp");
    rdchk(4'h3, 8'h0f, "sensor_relay");
    rdchk(4'he, 8'hff, "ignition");
    rdchk(4'ha, 8'hff, "config_upper");
    check("rd_hit_mapped", {7'h0, h}, 8'h01);
    rdchk(4'h0, 8'h00, "unmapped");
    check("rd_hit", {7'h0, h}, 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_stages();
    logic [2:0] k [3];
    logic [7:0] cfg [3];
    logic [7:0] ign [3];
    k   = '{3'b100, 3'b001, 3'b010};
    cfg = '{8'h0a, 8'h55, 8'ha0};
    ign = '{8'h00, 8'h55, 8'haa};
    for (int i = 0; i < 3; i++) begin
      stage_fault    = {4{k[i]}};
      ignition_fault = {4{k[i]}};
      rdchk(4'ha, cfg[i], "config_upper");
      rdchk(4'he, ign[i], "ignition");
    end
    stage_fault    = {3'b001, 3'b010, 3'b100, 3'b000};
    ignition_fault = {3'b001, 3'b010, 3'b100, 3'b000};
    rdchk(4'ha, 8'h6b, "config_mixed");
    rdchk(4'he, 8'h63, "ignition_mixed");
    $display("t_stages done");
  endtask : t_stages

  task automatic t_bridge();
    logic [7:0] e [7];
    e = '{8'hff, 8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07};
    bridge_mode = 1'b1;
    for (int i = 0; i < 7; i++) begin
      second_bridge_fault = diag_status_pkg::bridge_fault_t'(3'(i));
      rdchk(4'ha, e[i], "bridge_code");
    end
    bridge_mode = 1'b0;
    rdchk(4'ha, 8'h6b, "back_to_stages");
    stage_fault    = '0;
    ignition_fault = '0;
    $display("t_bridge done");
  endtask : t_bridge

  task automatic t_sensor();
    key_on_high = 1'b1;
    key_on_low  = 1'b0;
    rdchk(4'h3, 8'h8f, "key_on_high");
    key_on_high = 1'b0;
    rdchk(4'h3, 8'h8f, "key_on_between");
    key_on_low = 1'b1;
    main_relay_overcurrent_off = 1'b1;
    rdchk(4'h3, 8'h4f, "relay_ovc");
    main_relay_overcurrent_off = 1'b0;
    flywheel_diag_active  = 1'b1;
    flywheel_sensor_fault = 1'b1;
    rdchk(4'h3, 8'h2f, "flywheel_limited");
    flywheel_fully_adaptive = 1'b1;
    rdchk(4'h3, 8'h3f, "flywheel_full");
    flywheel_diag_active  = 1'b0;
    flywheel_sensor_fault = 1'b0;
    tracking_fault = {3'b110, 3'b001};
    rdchk(4'h3, 8'h06, "tracking_a");
    tracking_fault = {3'b010, 3'b101};
    rdchk(4'h3, 8'h09, "tracking_b");
    tracking_fault = '0;
    $display("t_sensor done");
  endtask : t_sensor

  task automatic t_sticky();
    logic [11:0] t [15];
    t = '{12'h702, 12'h710, 12'h740, 12'hb01, 12'hb02, 12'hb10, 12'hb20, 12'hb40,
          12'hb80, 12'hb08, 12'h701, 12'h704, 12'h708, 12'h720, 12'h780};
    for (int i = 14; i > 0; i--) begin
      events = diag_status_pkg::monitor_events_t'(15'h1 << i);
      @(negedge clk);
      events = '0;
      rdchk(t[i][11:8], t[i][7:0], "sticky_set");
      rdchk(t[i][11:8], 8'h00, "sticky_cleared");
    end
    events.tracking_overtemp    = 1'b1;
    events.stream_timeout_error = 1'b1;
    @(negedge clk);
    events = '0;
    u_diag_host_model.read2(4'hb, d, d1);
    check("first_of_pair", d, 8'h81);
    check("second_of_pair", d1, 8'h00);
    events.timeout_reset = 1'b1;
    rdchk(4'h7, 8'h80, "set_during_read");
    events = '0;
    rdchk(4'h7, 8'h80, "set_wins_read");
    rdchk(4'h7, 8'h00, "cleared_after");
    $display("t_sticky done");
  endtask : t_sticky

  task automatic t_outdis();
    events.outputs_disable_set = 1'b1;
    @(negedge clk);
    events = '0;
    rdchk(4'h7, 8'h02, "outputs_disabled_read");
    rdchk(4'h7, 8'h02, "outputs_disabled_kept");
    check("outputs_disabled", {7'h0, outputs_disabled}, 8'h01);
    software_reset_command = 1'b1;
    @(negedge clk);
    software_reset_command = 1'b0;
    check("sw_clear", {7'h0, outputs_disabled}, 8'h00);
    events.outputs_disable_set = 1'b1;
    @(negedge clk);
    reset_pin = 1'b1;
    @(negedge clk);
    events    = '0;
    reset_pin = 1'b0;
    check("pin_clear", {7'h0, outputs_disabled}, 8'h00);
    rdchk(4'h7, 8'h00, "after_clear");
    $display("t_outdis done");
  endtask : t_outdis

  task automatic t_midreset();
    rdchk(4'he, 8'hff, "before_reset");
    events = '1;
    @(negedge clk);
    check("dis_before_reset", {7'h0, outputs_disabled}, 8'h01);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    events  = '0;
    sys_rst = 1'b0;
    check("rd_data_reset", rd_data, 8'h00);
    check("rd_valid_reset", {7'h0, rd_valid}, 8'h00);
    check("dis_reset", {7'h0, outputs_disabled}, 8'h00);
    rdchk(4'h7, 8'h00, "rc_reset");
    rdchk(4'hb, 8'h00, "ot_reset");
    $display("t_midreset done");
  endtask : t_midreset

  // ==========================================================
  // clock, watchdog and main sequence
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_stages();
    t_bridge();
    t_sensor();
    t_sticky();
    t_outdis();
    t_midreset();
    conclude();
  end
endmodule : diagnostic_status_registers_tb_top
